//--- logic/scs_consts.vh
// Constants for the system clock and reset start-up controller
// Assumes inclusion by the divider and controller design files of the block
`ifndef SCS_CONSTS_VH
`define SCS_CONSTS_VH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define SCS_ADDR_BRK_STATUS   16'hfe00
`define SCS_ADDR_RST_CAUSE    16'hfe01
`define SCS_ADDR_BRK_CTRL     16'hfe03
`define SCS_ADDR_IRQ_STATUS   16'hfe04
`define SCS_ADDR_IRQ_ENABLE   16'hfe05
`define SCS_ADDR_IRQ_CLEAR    16'hfe06
`define SCS_ADDR_IRQ_SRC_LO   16'hfe08
`define SCS_ADDR_IRQ_SRC_MID  16'hfe09
`define SCS_ADDR_IRQ_SRC_HI   16'hfe0a

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define SCS_BIT_BRK_WAIT      1
`define SCS_BIT_BRK_CLR_EN    7
`define SCS_BIT_POWER_ON      7
`define SCS_BIT_EXT_PIN       6
`define SCS_BIT_WATCHDOG      5
`define SCS_BIT_BAD_OPCODE    4
`define SCS_BIT_BAD_ADDR      3
`define SCS_BIT_UNDERVOLT     1
`define SCS_RST_CAUSE_RESET   8'h80

// Interrupt status bits
`define SCS_EV_STARTUP_DONE   0
`define SCS_EV_CPU_RELEASE    1
`define SCS_EV_BRK_WAIT       2
`define SCS_EV_SRC_PEND       3
`define SCS_EV_WIDTH          4

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SCS_BUS_DIV           4
`define SCS_CLKGEN_DIV        2
`define SCS_POR_TIMEOUT       4096
`define SCS_CPU_REL_DELAY     64
`define SCS_CNT_WIDTH         13
`define SCS_IRQ_SOURCES       24

`endif

//--- logic/scs_clk_div.v
// Clock-enable divider that makes a one-cycle tick every DIV input ticks
// Assumes srcTick is a single-cycle strobe in the clk domain
`include "scs_consts.vh"

module scs_clk_div #(
  parameter DIV = 2
) (
  input  wire clk,
  input  wire sys_rst,
  input  wire run,
  input  wire srcTick,
  output reg  tick,
  output reg  phase
);

  reg [7:0] cnt_q;

  always @(posedge clk)
  begin
    if (sys_rst || !run)
    begin
      cnt_q <= 8'h00;
      tick  <= 1'b0;
      phase <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (srcTick)
      begin
        if (cnt_q == DIV[7:0] - 8'h01)
        begin
          cnt_q <= 8'h00;
          tick  <= 1'b1;
        end
        else
          cnt_q <= cnt_q + 8'h01;
        if (cnt_q == (DIV[7:0] >> 1) - 8'h01 ||
            cnt_q == DIV[7:0] - 8'h01)
          phase <= ~phase;
      end
    end
  end

endmodule

//--- logic/scs_sync.v
// Two-stage synchroniser for a level from outside the clk domain
// Assumes the input may change at any time
module scs_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         sys_rst,
  input  wire [W-1:0] asyncIn,
  output reg  [W-1:0] syncOut
);

  reg [W-1:0] meta_q;

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      meta_q  <= {W{1'b0}};
      syncOut <= {W{1'b0}};
    end
    else
    begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule

//--- logic/scs_startup_ctrl.v
// System clock and reset start-up controller with its status registers
// Assumes oscillator and power-on inputs are asynchronous; bus is on clk
//
// Overview of operation
// - Bus clock tick is clock generator output divided by two.
// - Internal bus rate is oscillator or PLL clock divided by four.
// - After power-on, CPU and peripheral clocks idle for 4096 osc cycles.
// - External reset pin driven low for the whole power-on timeout.
// - Internal bus clocks start only when the timeout has completed.
// - Writing zero to the break wait status flag clears it, unless a break wait event sets it in the same cycle.
// - Break status register holds the break wait flag in bit 1.
// - Reset cause register: por7 pin6 wdog5 opc4 addr3 uv1, reset 0x80.
// - Break flag control register holds clear enable in bit 7.
// - Up to 24 interrupt sources are accepted and reported.
// - Timeout counter is 13 bits, advancing on falling osc edges.
// - CPU and memories leave reset 64 osc cycles after the count.
// - Power-on sets the power-on flag and clears all other causes.
//
// The strobed register port is this design's own decision.
`include "scs_consts.vh"

module scs_startup_ctrl #(
  parameter POR_TIMEOUT = `SCS_POR_TIMEOUT,
  parameter REL_DELAY   = `SCS_CPU_REL_DELAY,
  parameter NSRC        = `SCS_IRQ_SOURCES
) (
  input  wire            clk,
  input  wire            sys_rst,
  input  wire            bufferedOscClock,
  input  wire            pllOutputClock,
  input  wire            pllSelect,
  input  wire            clockGeneratorOutput,
  input  wire            powerOnResetPulse,
  input  wire            extResetPinIn,
  input  wire            watchdogEvent,
  input  wire            badOpcodeEvent,
  input  wire            badFetchAddrEvent,
  input  wire            undervoltageEvent,
  input  wire            breakWaitEvent,
  input  wire [NSRC-1:0] irqSources,
  input  wire [15:0]     regAddr,
  input  wire [7:0]      regWrData,
  input  wire            regWrite,
  input  wire            regRead,
  output reg  [7:0]      regRdData,
  output wire            extResetPinOut,
  output wire            extResetPinOe,
  output reg             internalReset,
  output wire            internalBusClocks,
  output wire            busClockTick,
  output wire            internalBusTick,
  output wire            breakClearFlagEnable,
  output wire            irqOut
);

  // --------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------
  wire [6:0] syncIn;

  scs_sync #(.W(7)) uSync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .asyncIn ({bufferedOscClock, pllOutputClock, clockGeneratorOutput,
               powerOnResetPulse, extResetPinIn, watchdogEvent,
               undervoltageEvent}),
    .syncOut (syncIn)
  );

  wire oscS  = syncIn[6];
  wire pllS  = syncIn[5];
  wire cgoS  = syncIn[4];
  wire porS  = syncIn[3];
  wire pinS  = syncIn[2];
  wire wdgS  = syncIn[1];
  wire uvS   = syncIn[0];

  reg  oscPrev_q;
  reg  pllPrev_q;
  reg  cgoPrev_q;
  reg  porPrev_q;

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      oscPrev_q <= 1'b0;
      pllPrev_q <= 1'b0;
      cgoPrev_q <= 1'b0;
      porPrev_q <= 1'b0;
    end
    else
    begin
      oscPrev_q <= oscS;
      pllPrev_q <= pllS;
      cgoPrev_q <= cgoS;
      porPrev_q <= porS;
    end
  end

  wire oscFall  = oscPrev_q & ~oscS;
  wire oscRise  = ~oscPrev_q & oscS;
  wire pllRise  = ~pllPrev_q & pllS;
  wire cgoRise  = ~cgoPrev_q & cgoS;
  wire porStart = ~porPrev_q & porS;

  // --------------------------------------------------------------------
  // Start-up sequencer
  // --------------------------------------------------------------------
  localparam [1:0] ST_TIMEOUT = 2'd0;
  localparam [1:0] ST_RELEASE = 2'd1;
  localparam [1:0] ST_RUN     = 2'd2;

  reg [1:0]                  state_q;
  reg [`SCS_CNT_WIDTH-1:0]   cnt_q;
  reg                        clocksOn_q;

  always @(posedge clk)
  begin
    if (sys_rst || porS)
    begin
      state_q       <= ST_TIMEOUT;
      cnt_q         <= {`SCS_CNT_WIDTH{1'b0}};
      clocksOn_q    <= 1'b0;
      internalReset <= 1'b1;
    end
    else
    begin
      case (state_q)
        ST_TIMEOUT:
        begin
          if (oscFall)
          begin
            if (cnt_q == POR_TIMEOUT[`SCS_CNT_WIDTH-1:0] - 1'b1)
            begin
              cnt_q      <= {`SCS_CNT_WIDTH{1'b0}};
              clocksOn_q <= 1'b1;
              state_q    <= ST_RELEASE;
            end
            else
              cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_RELEASE:
        begin
          if (oscFall)
          begin
            if (cnt_q == REL_DELAY[`SCS_CNT_WIDTH-1:0] - 1'b1)
            begin
              internalReset <= 1'b0;
              state_q       <= ST_RUN;
            end
            else
              cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_RUN:
          internalReset <= 1'b0;
        default:
          state_q <= ST_TIMEOUT;
      endcase
    end
  end

  assign extResetPinOut = 1'b0;
  assign extResetPinOe  = (state_q == ST_TIMEOUT);
  assign internalBusClocks = clocksOn_q;

  // --------------------------------------------------------------------
  // Clock derivation
  // --------------------------------------------------------------------
  wire busSrcTick = pllSelect ? pllRise : oscRise;

  // Stop both dividers on the edge that a power-on restart drops clocks
  wire divRun = clocksOn_q & ~porS;

  scs_clk_div #(.DIV(`SCS_CLKGEN_DIV)) uBusDiv (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (divRun),
    .srcTick (cgoRise),
    .tick    (busClockTick),
    .phase   ()
  );

  scs_clk_div #(.DIV(`SCS_BUS_DIV)) uIbusDiv (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (divRun),
    .srcTick (busSrcTick),
    .tick    (internalBusTick),
    .phase   ()
  );

  // --------------------------------------------------------------------
  // Status and control registers
  // --------------------------------------------------------------------
  reg       brkWait_q;
  reg       brkClrEn_q;
  reg [7:0] rstCause_q;
  reg [NSRC-1:0]           srcLatch_q;
  reg [`SCS_EV_WIDTH-1:0]  irqStat_q;
  reg [`SCS_EV_WIDTH-1:0]  irqEn_q;

  wire wrBrk = regWrite && regAddr == `SCS_ADDR_BRK_STATUS;
  wire wrCtl = regWrite && regAddr == `SCS_ADDR_BRK_CTRL;
  wire wrEn  = regWrite && regAddr == `SCS_ADDR_IRQ_ENABLE;
  wire wrClr = regWrite && regAddr == `SCS_ADDR_IRQ_CLEAR;

  reg pinPrev_q;
  wire pinFall = pinPrev_q & ~pinS;

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      brkWait_q  <= 1'b0;
      brkClrEn_q <= 1'b0;
      rstCause_q <= `SCS_RST_CAUSE_RESET;
      pinPrev_q  <= 1'b0; // Synchroniser resets low; no false fall
      srcLatch_q <= {NSRC{1'b0}};
    end
    else
    begin
      pinPrev_q  <= pinS;
      srcLatch_q <= irqSources;
      if (breakWaitEvent)
        brkWait_q <= 1'b1;
      else if (wrBrk && !regWrData[`SCS_BIT_BRK_WAIT])
        brkWait_q <= 1'b0;
      if (wrCtl)
        brkClrEn_q <= regWrData[`SCS_BIT_BRK_CLR_EN];
      if (porStart)
        rstCause_q <= `SCS_RST_CAUSE_RESET;
      else
      begin
        if (pinFall)
          rstCause_q[`SCS_BIT_EXT_PIN] <= 1'b1;
        if (wdgS)
          rstCause_q[`SCS_BIT_WATCHDOG] <= 1'b1;
        if (badOpcodeEvent)
          rstCause_q[`SCS_BIT_BAD_OPCODE] <= 1'b1;
        if (badFetchAddrEvent)
          rstCause_q[`SCS_BIT_BAD_ADDR] <= 1'b1;
        if (uvS)
          rstCause_q[`SCS_BIT_UNDERVOLT] <= 1'b1;
      end
    end
  end

  assign breakClearFlagEnable = brkClrEn_q;

  // --------------------------------------------------------------------
  // Interrupt status, enable and clear
  // --------------------------------------------------------------------
  reg clocksPrev_q;
  reg relPrev_q;

  wire [`SCS_EV_WIDTH-1:0] evSet;
  assign evSet[`SCS_EV_STARTUP_DONE] = clocksOn_q & ~clocksPrev_q;
  assign evSet[`SCS_EV_CPU_RELEASE]  = ~internalReset & relPrev_q;
  assign evSet[`SCS_EV_BRK_WAIT]     = breakWaitEvent;
  assign evSet[`SCS_EV_SRC_PEND]     = |srcLatch_q;

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      irqStat_q    <= {`SCS_EV_WIDTH{1'b0}};
      irqEn_q      <= {`SCS_EV_WIDTH{1'b0}};
      clocksPrev_q <= 1'b0;
      relPrev_q    <= 1'b1;
    end
    else
    begin
      clocksPrev_q <= clocksOn_q;
      relPrev_q    <= internalReset;
      if (wrEn)
        irqEn_q <= regWrData[`SCS_EV_WIDTH-1:0];
      // Set wins over a clear in the same cycle
      irqStat_q <= (irqStat_q &
                    ~(wrClr ? regWrData[`SCS_EV_WIDTH-1:0]
                            : {`SCS_EV_WIDTH{1'b0}})) | evSet;
    end
  end

  assign irqOut = |(irqStat_q & irqEn_q);

  // --------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------
  function [7:0] srcByte;
    input [23:0] v;
    input [1:0]  idx;
    begin
      srcByte = v[idx*8 +: 8];
    end
  endfunction

  wire [23:0] srcPad = {{(24-NSRC){1'b0}}, srcLatch_q};

  always @(posedge clk)
  begin
    if (sys_rst)
      regRdData <= 8'h00;
    else if (regRead)
    begin
      case (regAddr)
        `SCS_ADDR_BRK_STATUS:
          regRdData <= {6'h00, brkWait_q, 1'b0};
        `SCS_ADDR_RST_CAUSE:
          regRdData <= rstCause_q & 8'hfa;
        `SCS_ADDR_BRK_CTRL:
          regRdData <= {brkClrEn_q, 7'h00};
        `SCS_ADDR_IRQ_STATUS:
          regRdData <= {4'h0, irqStat_q};
        `SCS_ADDR_IRQ_ENABLE:
          regRdData <= {4'h0, irqEn_q};
        `SCS_ADDR_IRQ_SRC_LO:
          regRdData <= srcByte(srcPad, 2'd0);
        `SCS_ADDR_IRQ_SRC_MID:
          regRdData <= srcByte(srcPad, 2'd1);
        `SCS_ADDR_IRQ_SRC_HI:
          regRdData <= srcByte(srcPad, 2'd2);
        default:
          regRdData <= 8'h00;
      endcase
    end
    else
      regRdData <= 8'h00;
  end

endmodule

//--- bench/scs_startup_checker.sv
// Port-level checks for the start-up controller
// Assumes a bind into scs_startup_ctrl; one clock domain
module scs_startup_checker #(
  parameter POR_TIMEOUT = 4096,
  parameter REL_DELAY   = 64
) (
  input wire        clk,
  input wire        sys_rst,
  input wire        bufferedOscClock,
  input wire        powerOnResetPulse,
  input wire [15:0] regAddr,
  input wire        regRead,
  input wire [7:0]  regRdData,
  input wire        extResetPinOut,
  input wire        extResetPinOe,
  input wire        internalReset,
  input wire        internalBusClocks,
  input wire        busClockTick,
  input wire        internalBusTick,
  input wire        breakClearFlagEnable
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] oscFalls_q;
  logic        oscPrev_q;
  // ----------------------------------------
  // Oscillator falls since reset or power-on
  // ----------------------------------------
  always @(posedge clk)
  begin
    oscPrev_q <= bufferedOscClock;
    if (sys_rst || powerOnResetPulse)
      oscFalls_q <= 16'h0000;
    else if (oscPrev_q && !bufferedOscClock)
      oscFalls_q <= oscFalls_q + 16'h0001;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_rd(a); regRead && regAddr == a; endsequence
  property p_pinLow;
    extResetPinOe |-> !extResetPinOut && internalReset;
  endproperty
  a_pinLow: assert property (p_pinLow)
    else $error("reset pin driven high");
  property p_start;
    $rose(internalBusClocks) |->
      !extResetPinOe && oscFalls_q == POR_TIMEOUT;
  endproperty
  a_start: assert property (p_start)
    else $error("clocks started at wrong count");
  property p_oeFell; $fell(extResetPinOe) |-> ##[0:1] internalBusClocks;
  endproperty
  a_oeFell: assert property (p_oeFell)
    else $error("bus clocks late after pin release");
  property p_rel;
    $fell(internalReset) |-> oscFalls_q == POR_TIMEOUT + REL_DELAY;
  endproperty
  a_rel: assert property (p_rel)
    else $error("cpu released at wrong count");
  property p_busTick;
    busClockTick |-> internalBusClocks ##1 !busClockTick[*4];
  endproperty
  a_busTick: assert property (p_busTick)
    else $error("bus tick too early");
  property p_ibTick;
    internalBusTick |-> internalBusClocks ##1 !internalBusTick[*8];
  endproperty
  a_ibTick: assert property (p_ibTick)
    else $error("internal bus tick too early");
  property p_idle; !regRead |=> regRdData == 8'h00; endproperty
  a_idle: assert property (p_idle)
    else $error("read data without read");
  property p_cause;
    s_rd(16'hfe01) |=> regRdData[2] == 1'b0 && regRdData[0] == 1'b0;
  endproperty
  a_cause: assert property (p_cause)
    else $error("cause bits 2 or 0 set");
  property p_ctl;
    s_rd(16'hfe03) |=> regRdData[7] == $past(breakClearFlagEnable);
  endproperty
  a_ctl: assert property (p_ctl)
    else $error("clear enable read mismatch");
endmodule

//--- bench/scs_far_model.sv
// Clock generator and power-on detector model
// Assumes clk at 50 MHz; all clocks counted off clk
module scs_far_model (
  input  wire  clk,
  input  wire  porReq,
  output logic bufferedOscClock,
  output logic pllOutputClock,
  output logic clockGeneratorOutput,
  output logic powerOnResetPulse
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_q = 0;
  initial powerOnResetPulse = 1'b0;
  always @(posedge clk)
  begin
    cnt_q <= (cnt_q == 59) ? 0 : cnt_q + 1;
    if (porReq)
      powerOnResetPulse <= 1'b1;
    else if (cnt_q % 10 == 9)
      powerOnResetPulse <= 1'b0;
  end
  // Pulse ends on an oscillator rise
  assign bufferedOscClock     = (cnt_q % 10) < 5;
  assign pllOutputClock       = (cnt_q % 12) < 6;
  assign clockGeneratorOutput = (cnt_q % 6) < 3;
endmodule

//--- bench/testbench.sv
// Self-checking bench for the start-up controller
// Assumes scs_far_model supplies clocks and the power-on pulse
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int POR_TIMEOUT = 16;
  localparam int REL_DELAY   = 4;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        porReq = 1'b0;
  logic        pllSelect = 1'b0;
  logic        extResetPinIn = 1'b1;
  logic [4:0]  ev = 5'h00;
  logic [23:0] irqSources = 24'h000000;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0]  regWrData = 8'h00;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  wire         bufferedOscClock, pllOutputClock, clockGeneratorOutput;
  wire         powerOnResetPulse, extResetPinOut, extResetPinOe;
  wire         internalReset, internalBusClocks, busClockTick;
  wire         internalBusTick, breakClearFlagEnable, irqOut;
  wire  [7:0]  regRdData;
  int          failures = 0;
  int          tests_run = 0;
  always #10 clk = ~clk;
  scs_far_model scs_far_model_i (.clk, .porReq, .bufferedOscClock,
    .pllOutputClock, .clockGeneratorOutput, .powerOnResetPulse);
  scs_startup_ctrl #(.POR_TIMEOUT(POR_TIMEOUT), .REL_DELAY(REL_DELAY))
    scs_startup_ctrl_i (.clk, .sys_rst, .bufferedOscClock, .pllOutputClock,
    .pllSelect, .clockGeneratorOutput, .powerOnResetPulse, .extResetPinIn,
    .watchdogEvent(ev[0]), .badOpcodeEvent(ev[1]),
    .badFetchAddrEvent(ev[2]), .undervoltageEvent(ev[3]),
    .breakWaitEvent(ev[4]), .irqSources, .regAddr, .regWrData, .regWrite,
    .regRead, .regRdData, .extResetPinOut, .extResetPinOe, .internalReset,
    .internalBusClocks, .busClockTick, .internalBusTick,
    .breakClearFlagEnable, .irqOut);
  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] m, e);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    check(regRdData & m, e);
  endtask
  task automatic pulse(input logic [4:0] v, input int n);
    @(posedge clk);
    ev <= v;
    repeat (n) @(posedge clk);
    ev <= 5'h00;
    cyc(3);
  endtask
  task automatic gap(input logic s, input int e);
    int n;
    n = 0;
    while ((s ? internalBusTick : busClockTick) !== 1'b1 && n < 100)
    begin
      cyc();
      n++;
    end
    n = 0;
    do
    begin
      cyc();
      n++;
    end while ((s ? internalBusTick : busClockTick) !== 1'b1 && n < 100);
    check(n, e);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_startup;
    int i;
    check(extResetPinOe, 1'b1);
    check(internalBusClocks, 1'b0);
    for (i = 0; i < 400 && internalBusClocks !== 1'b1; i++)
      cyc();
    check(internalBusClocks, 1'b1);
    check(extResetPinOe, 1'b0);
    check(internalReset, 1'b1);
    for (i = 0; i < 100 && internalReset !== 1'b0; i++)
      cyc();
    check(internalReset, 1'b0);
    $display("startup done");
  endtask
  task automatic t_regs;
    rdc(16'hfe01, 8'hff, 8'h80);
    rdc(16'hfe00, 8'h02, 8'h00);
    rdc(16'hfe03, 8'h80, 8'h00);
    rdc(16'hfe02, 8'hff, 8'h00);
    $display("reset values done");
  endtask
  task automatic t_ticks;
    gap(1'b0, 12);
    gap(1'b1, 40);
    @(posedge clk);
    pllSelect <= 1'b1;
    cyc(100);
    gap(1'b1, 48);
    $display("ticks done");
  endtask
  task automatic t_causes;
    pulse(5'h02, 1);
    pulse(5'h04, 1);
    pulse(5'h09, 4);
    @(posedge clk);
    extResetPinIn <= 1'b0;
    cyc(4);
    @(posedge clk);
    extResetPinIn <= 1'b1;
    cyc(4);
    rdc(16'hfe01, 8'hff, 8'hfa);
    wr(16'hfe01, 8'h00);
    rdc(16'hfe01, 8'hff, 8'hfa);
    $display("causes done");
  endtask
  task automatic t_por;
    @(posedge clk);
    porReq <= 1'b1;
    cyc(3);
    @(posedge clk);
    porReq <= 1'b0;
    cyc(4);
    rdc(16'hfe01, 8'hff, 8'h80);
    t_startup();
    $display("power-on done");
  endtask
  task automatic t_break;
    pulse(5'h10, 1);
    rdc(16'hfe00, 8'h02, 8'h02);
    wr(16'hfe00, 8'hff);
    rdc(16'hfe00, 8'h02, 8'h02);
    wr(16'hfe00, 8'h00);
    rdc(16'hfe00, 8'h02, 8'h00);
    wr(16'hfe03, 8'h80);
    check(breakClearFlagEnable, 1'b1);
    rdc(16'hfe03, 8'h80, 8'h80);
    wr(16'hfe03, 8'h00);
    check(breakClearFlagEnable, 1'b0);
    $display("break done");
  endtask
  task automatic t_irq;
    wr(16'hfe06, 8'h0f);
    wr(16'hfe05, 8'h04);
    check(irqOut, 1'b0);
    pulse(5'h10, 1);
    check(irqOut, 1'b1);
    wr(16'hfe05, 8'h00);
    check(irqOut, 1'b0);
    wr(16'hfe05, 8'h04);
    check(irqOut, 1'b1);
    wr(16'hfe06, 8'h04);
    check(irqOut, 1'b0);
    rdc(16'hfe04, 8'hff, 8'h00);
    @(posedge clk);
    irqSources <= 24'ha5c3e1;
    cyc(2);
    rdc(16'hfe08, 8'hff, 8'he1);
    rdc(16'hfe09, 8'hff, 8'hc3);
    rdc(16'hfe0a, 8'hff, 8'ha5);
    rdc(16'hfe04, 8'hff, 8'h08);
    $display("interrupts done");
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    // Release lands while the model oscillator is low
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    cyc();
    t_regs();
    t_startup();
    t_ticks();
    t_causes();
    t_por();
    t_break();
    t_irq();
    close_out();
  end
  initial
  begin
    cyc(5000);
    failures++;
    close_out();
  end
endmodule
bind scs_startup_ctrl scs_startup_checker #(.POR_TIMEOUT(POR_TIMEOUT),
  .REL_DELAY(REL_DELAY)) scs_startup_checker_i (.clk, .sys_rst,
  .bufferedOscClock, .powerOnResetPulse, .regAddr, .regRead, .regRdData,
  .extResetPinOut, .extResetPinOe, .internalReset, .internalBusClocks,
  .busClockTick, .internalBusTick, .breakClearFlagEnable);
